//--- design/scfg_port.sv
`timescale 1ns/1ps
`include "scfg_params.svh"

module scfg_port
  import scfg_pkg::*;
#(
  parameter logic [15:0] PART_CODE    = 16'hA5C3,  // Arbitrary value
  parameter logic [47:0] PRODUCT_CODE = 48'h0000_1234_5678, // Arbitrary value
  parameter logic [23:0] FUSE_PINOV   = `SCFG_R_PINOV,
  parameter logic [31:0] FUSE_REFCFG  = `SCFG_R_REFCFG,
  parameter logic [15:0] FUSE_IOBUF   = `SCFG_R_IOBUF,
  parameter logic [31:0] FUSE_OUTDIV  = `SCFG_R_OUTDIV,
  parameter logic [39:0] FUSE_FBDIV   = `SCFG_R_FBDIV,
  parameter logic [39:0] FUSE_LOOP    = `SCFG_R_LOOP,
  parameter logic [31:0] FUSE_BAND    = `SCFG_R_BAND
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire scfg_spi_type     spi,
  input  wire scfg_pin_type     pins,
  input  wire logic             pll_lock,
  output logic                  sdo,
  output logic                  sdo_oe,
  output logic                  out1_drive_en,
  output logic                  out2_drive_en,
  output logic                  ref_drive_en,
  output logic [9:0]            out1_half_div,
  output logic [9:0]            out2_half_div,
  output scfg_fb_form_type      fb_form,
  output logic                  fbdiv_restart,
  output logic                  output_div_restart,
  output scfg_core_type         core
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  scfg_spi_type spi_s1;      // First stage, read only by second
  scfg_spi_type spi_s2;      // Usable stage
  scfg_spi_type spi_s3;      // Previous value for edge finding
  scfg_pin_type pin_s1;      // Enable pins, first stage
  scfg_pin_type pin_s2;      // Enable pins, usable
  logic         lock_s1;     // Lock, first stage
  logic         lock_s2;     // Lock, usable

  // Two flops on every asynchronous input, then an edge history
  always_ff @(posedge clk) begin
    if (!nrst) begin
      spi_s1  <= 3'b010;
      spi_s2  <= 3'b010;
      spi_s3  <= 3'b010;
      pin_s1  <= '0;
      pin_s2  <= '0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
    end else begin
      spi_s1  <= spi;
      spi_s2  <= spi_s1;
      spi_s3  <= spi_s2;
      pin_s1  <= pins;
      pin_s2  <= pin_s1;
      lock_s1 <= pll_lock;
      lock_s2 <= lock_s1;
    end
  end

  logic sck_rise;            // Rising SCK seen this cycle
  logic sck_fall;            // Falling SCK seen this cycle
  logic sel_fall;            // Select just asserted
  logic selected;            // Select held low
  assign sck_rise = spi_s2.sck & ~spi_s3.sck;
  assign sck_fall = ~spi_s2.sck & spi_s3.sck;
  assign sel_fall = ~spi_s2.select_n & spi_s3.select_n;
  assign selected = ~spi_s2.select_n & ~spi_s3.select_n;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  scfg_state_type state;     // Protocol phase
  logic [7:0]     rx;        // Incoming byte
  logic [2:0]     bit_cnt;   // Bits of current byte
  logic           byte_rdy;  // Eighth bit taken, awaiting its fall
  logic [2:0]     byte_idx;  // Data byte number after command
  logic [3:0]     addr;      // Addressed register
  logic [47:0]    tx;        // Outgoing shift register
  logic [63:0]    sizes;     // Byte size table
  logic [3:0]     size;      // Size of addressed register
  logic [3:0]     cmd_size;  // Size of address in arriving byte
  logic           byte_end;  // Fall that closes a byte
  logic           wr_ok;     // Data byte lands inside the register
  logic [2:0]     wr_pos;    // Byte lane being written
  logic [47:0]    rd_val;    // Read image, left aligned

  assign sizes    = `SCFG_SIZES;
  assign size     = sizes[{addr, 2'b00} +: 4];
  assign cmd_size = sizes[{rx[3:0], 2'b00} +: 4];
  assign byte_end = sck_fall & byte_rdy & selected;
  // Surplus bytes past the register size are dropped
  assign wr_ok    = (state == ST_WRITE) & byte_end & ({1'b0, byte_idx} < size);
  assign wr_pos   = 3'(size - 4'h1 - {1'b0, byte_idx});

  // Phase sequencing; select fall always restarts at the command byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else if (spi_s2.select_n) begin
      state <= ST_IDLE;
    end else if (sel_fall) begin
      state <= ST_CMD;
    end else if (byte_end && state == ST_CMD) begin
      unique case (rx[7:4])
        `SCFG_OP_WR: state <= ST_WRITE;
        `SCFG_OP_RD: state <= ST_READ;
        default:     state <= ST_IGNORE;
      endcase
    end
  end

  // Address latch; the phase alone carries the code, so deselect needs no clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr <= 4'h0;
    end else if (byte_end && state == ST_CMD) begin
      addr <= rx[3:0];
    end
  end

  // Bit assembly on rising SCK, MSB first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx       <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_rdy <= 1'b0;
    end else if (spi_s2.select_n || sel_fall) begin
      bit_cnt  <= 3'h0;
      byte_rdy <= 1'b0;
    end else if (sck_rise && selected) begin
      rx       <= {rx[6:0], spi_s2.sdi};
      bit_cnt  <= bit_cnt + 3'h1;
      byte_rdy <= (bit_cnt == 3'h7);
    end else if (byte_end) begin
      byte_rdy <= 1'b0;
    end
  end

  // Data byte counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      byte_idx <= 3'h0;
    end else if (spi_s2.select_n || sel_fall) begin
      byte_idx <= 3'h0;
    end else if (byte_end && state == ST_WRITE && byte_idx != 3'h7) begin
      byte_idx <= byte_idx + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [23:0] lock_status;  // Read-only lock register
  logic [39:0] fb_stage;     // Holding bytes of 0x6 until complete

  // Replace one byte lane of a value
  function automatic logic [47:0] put_byte(input logic [47:0] v,
                                           input logic [2:0]  p,
                                           input logic [7:0]  b);
    logic [47:0] r;
    r = v;
    r[p*8 +: 8] = b;
    return r;
  endfunction

  // Byte writes; select edges never touch the bank
  always_ff @(posedge clk) begin
    if (!nrst) begin
      core.pin_override_control  <= FUSE_PINOV;
      core.reference_path_config <= FUSE_REFCFG;
      core.io_buffer_config      <= FUSE_IOBUF;
      core.output_divide_values  <= FUSE_OUTDIV;
      core.feedback_divide_value <= FUSE_FBDIV;
      core.loop_parameters       <= FUSE_LOOP;
      core.vco_band_select       <= FUSE_BAND;
      fb_stage                   <= FUSE_FBDIV;
    end else if (wr_ok) begin
      unique case (addr)
        `SCFG_A_PINOV:  core.pin_override_control  <=
          24'(put_byte({24'h0, core.pin_override_control}, wr_pos, rx));
        `SCFG_A_REFCFG: core.reference_path_config <=
          32'(put_byte({16'h0, core.reference_path_config}, wr_pos, rx));
        `SCFG_A_IOBUF:  core.io_buffer_config      <=
          16'(put_byte({32'h0, core.io_buffer_config}, wr_pos, rx));
        `SCFG_A_OUTDIV: core.output_divide_values  <=
          32'(put_byte({16'h0, core.output_divide_values}, wr_pos, rx));
        `SCFG_A_FBDIV: begin
          // Staged so the core never sees a half-written divider
          fb_stage <= 40'(put_byte({8'h0, fb_stage}, wr_pos, rx));
          if (wr_pos == 3'h0) begin
            core.feedback_divide_value <= {fb_stage[39:8], rx};
          end
        end
        `SCFG_A_LOOP:   core.loop_parameters       <=
          40'(put_byte({8'h0, core.loop_parameters}, wr_pos, rx));
        `SCFG_A_BAND:   core.vco_band_select       <=
          32'(put_byte({16'h0, core.vco_band_select}, wr_pos, rx));
        default: ;
      endcase
    end
  end

  // Lock flag tracks the synchronised analog indicator
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_status <= `SCFG_R_LOCK;
    end else begin
      lock_status[`SCFG_B_LOCK] <= lock_s2;
    end
  end

  // Read image of the addressed register, left aligned to bit 47
  always_comb begin
    logic [47:0] raw;
    raw = 48'h0;
    unique case (rx[3:0])
      `SCFG_A_CHIP:   raw = {16'h0, PART_CODE, 16'h0000};
      `SCFG_A_PROD:   raw = PRODUCT_CODE;
      `SCFG_A_PINOV:  raw = {24'h0, core.pin_override_control};
      `SCFG_A_REFCFG: raw = {16'h0, core.reference_path_config};
      `SCFG_A_IOBUF:  raw = {32'h0, core.io_buffer_config};
      `SCFG_A_OUTDIV: raw = {16'h0, core.output_divide_values};
      `SCFG_A_FBDIV:  raw = {8'h0, core.feedback_divide_value};
      `SCFG_A_LOOP:   raw = {8'h0, core.loop_parameters};
      `SCFG_A_BAND:   raw = {16'h0, core.vco_band_select};
      `SCFG_A_LOCK:   raw = {24'h0, lock_status};
      default:        raw = 48'h0;                        // Reserved read as zero
    endcase
    rd_val = raw << {3'(4'h6 - cmd_size), 3'b000};
  end

  // Serial output: loaded at the command byte's last fall, shifted per fall
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx     <= 48'h0;
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (spi_s2.select_n || sel_fall) begin
      sdo_oe <= 1'b0;
      sdo    <= 1'b0;
    end else if (byte_end && state == ST_CMD && rx[7:4] == `SCFG_OP_RD) begin
      tx     <= rd_val;
      sdo    <= rd_val[47];
      sdo_oe <= 1'b1;
    end else if (sck_fall && selected && state == ST_READ) begin
      tx     <= {tx[46:0], 1'b0};
      sdo    <= tx[46];
    end
  end

  // ----------------------------------------------------------------
  // Core-facing decode
  // ----------------------------------------------------------------
  logic [7:0] div1_code;     // Programmed output one divisor
  logic [7:0] div2_code;     // Programmed output two divisor
  logic [1:0] s_field;       // Ratio scale select
  logic       loop_fb_prev;  // Last feedback restart bit
  logic       loop_od_prev;  // Last output restart bit
  assign div1_code = core.output_divide_values[7:0];
  assign div2_code = core.output_divide_values[15:8];
  assign s_field   = core.loop_parameters[`SCFG_B_S_LO +: 2];

  // Codes 0..3 mean 256..259; the half-step select overrides all
  function automatic logic [9:0] half_div(input logic [7:0] c, input logic h);
    logic [8:0] n;
    n = (c < 8'h04) ? {1'b1, c} : {1'b0, c};
    return h ? `SCFG_HALF_4P5 : {n, 1'b0};
  endfunction

  // Divisors in half steps and effective enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out1_half_div <= 10'h000;
      out2_half_div <= 10'h000;
      out1_drive_en <= 1'b0;
      out2_drive_en <= 1'b0;
      ref_drive_en  <= 1'b0;
    end else begin
      out1_half_div <= half_div(div1_code,
        core.reference_path_config[`SCFG_B_HALF1]);
      out2_half_div <= half_div(div2_code,
        core.reference_path_config[`SCFG_B_HALF2]);
      out1_drive_en <= core.pin_override_control[`SCFG_B_OE1TK] ?
        core.pin_override_control[`SCFG_B_OE1] : pin_s2.oe_one;
      out2_drive_en <= core.pin_override_control[`SCFG_B_OE2TK] ?
        core.pin_override_control[`SCFG_B_OE2] : pin_s2.oe_two;
      ref_drive_en  <= core.pin_override_control[`SCFG_B_REFTK] ?
        core.pin_override_control[`SCFG_B_REFOE] : pin_s2.oe_ref;
    end
  end

  // Feedback form from ratio bit and S field
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fb_form <= FB_PLAIN;
    end else if (!core.loop_parameters[`SCFG_B_RATIO]) begin
      fb_form <= FB_PLAIN;
    end else begin
      unique case (s_field)
        2'h0: fb_form <= FB_RATIO_8;
        2'h1: fb_form <= FB_RATIO_4;
        2'h2: fb_form <= FB_RATIO_2;
        2'h3: fb_form <= FB_RATIO_1;
      endcase
    end
  end

  // Restart pulses on the host's 0-to-1 toggle of the reset bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      loop_fb_prev       <= 1'b0;
      loop_od_prev       <= 1'b0;
      fbdiv_restart      <= 1'b0;
      output_div_restart <= 1'b0;
    end else begin
      loop_fb_prev       <= core.loop_parameters[`SCFG_B_FBRST];
      loop_od_prev       <= core.loop_parameters[`SCFG_B_ODRST];
      fbdiv_restart      <= core.loop_parameters[`SCFG_B_FBRST] & ~loop_fb_prev;
      output_div_restart <= core.loop_parameters[`SCFG_B_ODRST] & ~loop_od_prev;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sdo_released:
    assert property (@(posedge clk) disable iff (!nrst)
      spi_s2.select_n |=> !sdo_oe)
    else $error("serial output driven while deselected");
  a_cmd_restart:
    assert property (@(posedge clk) disable iff (!nrst)
      sel_fall |=> state == ST_CMD && bit_cnt == 3'h0)
    else $error("select fall did not restart command phase");
  a_nop_quiet:
    assert property (@(posedge clk) disable iff (!nrst)
      state == ST_IGNORE |-> !sdo_oe && !wr_ok)
    else $error("unknown code caused activity");
  a_bank_stable:
    assert property (@(posedge clk) disable iff (!nrst)
      !$past(wr_ok) |-> $stable(core))
    else $error("register changed without a data byte");
  a_half_step:
    assert property (@(posedge clk) disable iff (!nrst)
      core.reference_path_config[`SCFG_B_HALF1] |=> out1_half_div == 10'h009)
    else $error("output one not at 4.5");
  a_form_ratio:
    assert property (@(posedge clk) disable iff (!nrst)
      core.loop_parameters[`SCFG_B_RATIO] && s_field == 2'h3 |=> fb_form == FB_RATIO_1)
    else $error("S equal 3 not decoded");
  a_lock_flag:
    assert property (@(posedge clk) disable iff (!nrst)
      ##1 lock_status[`SCFG_B_LOCK] == $past(lock_s2))
    else $error("lock flag does not follow lock");
  a_oe1_pin:
    assert property (@(posedge clk) disable iff (!nrst)
      !core.pin_override_control[`SCFG_B_OE1TK] ##1
      !core.pin_override_control[`SCFG_B_OE1TK] |-> out1_drive_en == $past(pin_s2.oe_one))
    else $error("output one enable ignores pin");

  a_oe2_reg:
    assert property (@(posedge clk) disable iff (!nrst)
      core.pin_override_control[`SCFG_B_OE2TK] |=>
      out2_drive_en == $past(core.pin_override_control[`SCFG_B_OE2]))
    else $error("output two enable ignores register");

endmodule // scfg_port

//--- design/scfg_params.svh
`ifndef SCFG_PARAMS_SVH
`define SCFG_PARAMS_SVH
// Register addresses
`define SCFG_A_CHIP   4'h0
`define SCFG_A_PROD   4'h1
`define SCFG_A_PINOV  4'h2
`define SCFG_A_REFCFG 4'h3
`define SCFG_A_IOBUF  4'h4
`define SCFG_A_OUTDIV 4'h5
`define SCFG_A_FBDIV  4'h6
`define SCFG_A_LOOP   4'h7
`define SCFG_A_RSV8   4'h8
`define SCFG_A_BAND   4'hC
`define SCFG_A_LOCK   4'hF
// Byte size of each address, one nibble each, address 0 lowest
`define SCFG_SIZES    64'h3444_4255_5542_4364
// Reset values
`define SCFG_R_PINOV  24'h00AA0A
`define SCFG_R_REFCFG 32'h100F0000
`define SCFG_R_IOBUF  16'h0000
`define SCFG_R_OUTDIV 32'h00000000
`define SCFG_R_FBDIV  40'h000000000E
`define SCFG_R_LOOP   40'h0000000000
`define SCFG_R_BAND   32'h00000000
`define SCFG_R_LOCK   24'h060000
// Command codes
`define SCFG_OP_NOP   4'h0
`define SCFG_OP_WR    4'h1
`define SCFG_OP_RD    4'h2
// Field positions
`define SCFG_B_REFOE  17
`define SCFG_B_REFTK  16
`define SCFG_B_OE2    11
`define SCFG_B_OE2TK  10
`define SCFG_B_OE1    9
`define SCFG_B_OE1TK  8
`define SCFG_B_HALF2  9
`define SCFG_B_HALF1  8
`define SCFG_B_FBRST  14
`define SCFG_B_ODRST  13
`define SCFG_B_RATIO  10
`define SCFG_B_S_LO   21
`define SCFG_B_LOCK   21
// Divide-by-4.5 expressed in half steps
`define SCFG_HALF_4P5 10'h009
`endif

//--- design/scfg_pkg.sv
package scfg_pkg;
  // Serial link pins as seen by the device
  typedef struct packed {
    logic sck;
    logic select_n;
    logic sdi;
  } scfg_spi_type;
  // Enable pins of the three clock outputs
  typedef struct packed {
    logic oe_ref;
    logic oe_two;
    logic oe_one;
  } scfg_pin_type;
  // Configuration image handed to the analog core
  typedef struct packed {
    logic [23:0] pin_override_control;
    logic [31:0] reference_path_config;
    logic [15:0] io_buffer_config;
    logic [31:0] output_divide_values;
    logic [39:0] feedback_divide_value;
    logic [39:0] loop_parameters;
    logic [31:0] vco_band_select;
  } scfg_core_type;
  // Protocol phases
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WRITE, ST_READ, ST_IGNORE} scfg_state_type;
  // Feedback divider interpretation
  typedef enum logic [2:0] {FB_PLAIN, FB_RATIO_8, FB_RATIO_4, FB_RATIO_2, FB_RATIO_1}
    scfg_fb_form_type;
endpackage

//--- testbench/scfg_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Serial host model, mode 0, 300 ns SCK
// ----------------------------------------
module scfg_host_model
  import scfg_pkg::*;
(
  output scfg_spi_type spi,     // Link pins toward the device
  input  wire logic    sdo,     // Device serial output
  input  wire logic    sdo_oe   // Device output enable
);
  // Idle: deselected, clock low
  initial spi = '{sck: 1'b0, select_n: 1'b1, sdi: 1'b0};
  logic oe_seen = 1'b0;         // Device drove its output during the last frame

  // One framed transfer: command byte then nb data bytes
  task automatic frame(input logic [7:0] cmd, input int nb, input logic [47:0] wd,
                       output logic [47:0] rd);
    logic [55:0] sh;
    sh = {cmd, 48'(wd << (48 - 8 * nb))};
    rd = '0;
    oe_seen = 1'b0;
    spi.select_n = 1'b0;
    #400;
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      spi.sdi = sh[55 - i];
      #100 spi.sck = 1'b1;
      #90;
      if (sdo_oe) oe_seen = 1'b1;
      // Undriven line counts as unknown
      if (i >= 8) begin
        rd = {rd[46:0], sdo_oe ? sdo : 1'bx};
      end
      #10 spi.sck = 1'b0;
      #100;
    end
    #200 spi.select_n = 1'b1;
    // Released line must not show the last bit
    spi.sdi = ~spi.sdi;
    #400;
  endtask

  // Cut frame: only the first nbits of cmd, then select released
  task automatic stub(input logic [7:0] cmd, input int nbits);
    spi.select_n = 1'b0;
    #400;
    for (int i = 0; i < nbits; i++) begin
      spi.sdi = cmd[7 - i];
      #100 spi.sck = 1'b1;
      #100 spi.sck = 1'b0;
      #100;
    end
    #200 spi.select_n = 1'b1;
    #400;
  endtask
endmodule // scfg_host_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "scfg_params.svh"

module testbench;
  import scfg_pkg::*;
  localparam logic [15:0] ID_CODE = 16'h5A3C;  // Arbitrary value
  localparam logic [47:0] PROD_CODE = 48'h3C5A_0F1E_2D4B; // Arbitrary value
  logic             clk;                       // 40 MHz
  logic             nrst;                      // Sync reset
  scfg_spi_type     spi;                       // From host model
  scfg_pin_type     pins;                      // Enable pins
  logic             pll_lock;                  // Lock indicator
  logic             sdo, sdo_oe, en1, en2, enr, fbr, odr;
  logic [9:0]       h1, h2;                    // Half-step divisors
  scfg_fb_form_type fb_form;                   // Divider form
  scfg_core_type    core;                      // Register image
  int               bad_count = 0;
  int               checks = 0;
  int               n_fb = 0, n_od = 0;        // Restart pulse counts
  logic [15:0]      seed = 16'h0037;           // Random state, starts at 55
  logic [47:0]      v, r;

  scfg_port #(.PART_CODE(ID_CODE), .PRODUCT_CODE(PROD_CODE)) DUT (
    .clk(clk), .nrst(nrst), .spi(spi), .pins(pins), .pll_lock(pll_lock),
    .sdo(sdo), .sdo_oe(sdo_oe), .out1_drive_en(en1), .out2_drive_en(en2),
    .ref_drive_en(enr), .out1_half_div(h1), .out2_half_div(h2), .fb_form(fb_form),
    .fbdiv_restart(fbr), .output_div_restart(odr), .core(core));
  scfg_host_model host (.spi(spi), .sdo(sdo), .sdo_oe(sdo_oe));

  // ----------------------------------------
  // Clock, pulse counting, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (fbr === 1'b1) n_fb++;
    if (odr === 1'b1) n_od++;
  end
  // Run needs well under 1 ms; 2 ms means a hang
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Divisor code to half steps: codes below 4 mean 256..259
  function automatic logic [9:0] half_of(input logic [7:0] d);
    return (d < 8'h04) ? 10'((256 + d) * 2) : 10'(d * 2);
  endfunction
  task automatic check(input string name, input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    pins = '0;
    pll_lock = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    check("pinov", core.pin_override_control, `SCFG_R_PINOV);
    check("refcfg", core.reference_path_config, `SCFG_R_REFCFG);
    check("fbdiv", core.feedback_divide_value, `SCFG_R_FBDIV);
    check("loop", core.loop_parameters, `SCFG_R_LOOP);
    check("iobuf_rst", core.io_buffer_config, `SCFG_R_IOBUF);
    check("outdiv_rst", core.output_divide_values, `SCFG_R_OUTDIV);
    check("band_rst", core.vco_band_select, `SCFG_R_BAND);
    check("form_rst", fb_form, FB_PLAIN);
    check("oe_idle", sdo_oe, 1'b0);
    // Random output divisors written and read back
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v[31:16] = seed;
      seed = lfsr(seed);
      v[15:0] = (i == 0) ? 16'h0A03 : seed;
      host.frame(8'h15, 4, v, r);
      check("outdiv", core.output_divide_values, v[31:0]);
      check("half1", h1, half_of(v[7:0]));
      check("half2", h2, half_of(v[15:8]));
      host.frame(8'h25, 4, '0, r);
      check("outdiv_rd", r[31:0], v[31:0]);
    end
    // Nop and reserved codes leave the register alone
    host.frame(8'h05, 4, 48'h1111_1111, r);
    host.frame(8'h35, 4, 48'h2222_2222, r);
    check("outdiv_nop", core.output_divide_values, v[31:0]);
    check("oe_nop", sdo_oe, 1'b0);
    check("oe_nop_frame", host.oe_seen, 1'b0);
    // Cut frame: select released mid command, next frame starts clean
    host.stub(8'h15, 5);
    host.frame(8'h25, 4, '0, r);
    check("cut_frame", r[31:0], v[31:0]);
    // Feedback divider only commits on its fifth byte
    host.frame(8'h16, 4, 48'hDEAD_BEEF, r);
    check("fb_part", core.feedback_divide_value, `SCFG_R_FBDIV);
    host.frame(8'h16, 5, 48'h12_3456_7890, r);
    check("fb_full", core.feedback_divide_value, 40'h12_3456_7890);
    // Identification is read only
    host.frame(8'h10, 4, 48'hFFFF_FFFF, r);
    host.frame(8'h20, 4, '0, r);
    check("chip_identification", r[31:0], {ID_CODE, 16'h0000});
    host.frame(8'h21, 6, '0, r);
    check("prod_id", r, PROD_CODE);
    // Band and buffer registers, random contents
    seed = lfsr(seed);
    v = {16'h0000, seed, ~seed};
    host.frame(8'h1C, 4, v, r);
    check("band", core.vco_band_select, v[31:0]);
    host.frame(8'h2C, 4, '0, r);
    check("band_rd", r[31:0], v[31:0]);
    host.frame(8'h14, 2, v, r);
    check("iobuf", core.io_buffer_config, v[15:0]);
    host.frame(8'h24, 2, '0, r);
    check("iobuf_rd", r[15:0], v[15:0]);
    // Restart strobes and every ratio form
    for (int s = 0; s < 4; s++) begin
      host.frame(8'h17, 5, 48'(s << 21) | 48'h0000_6400, r);
      check("form", fb_form, scfg_fb_form_type'(s + 1));
    end
    check("fb_restart", n_fb, 1);
    check("od_restart", n_od, 1);
    // Ratio off, output restart bit lowered, then raised again
    host.frame(8'h17, 5, 48'h0000_4000, r);
    check("form_plain", fb_form, FB_PLAIN);
    host.frame(8'h17, 5, 48'h0000_6000, r);
    check("od_restart2", n_od, 2);
    check("fb_restart2", n_fb, 1);
    // Half-step selects
    host.frame(8'h13, 4, 48'(`SCFG_R_REFCFG) | 48'h0300, r);
    check("half1_45", h1, `SCFG_HALF_4P5);
    check("half2_45", h2, `SCFG_HALF_4P5);
    // Enables follow pins, then register bits once taken over
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      v = (i < 3) ? 48'h0 : {30'h0, seed[2], 1'b1, 4'h0, seed[1], 1'b1, seed[0], 1'b1, 8'h00};
      host.frame(8'h12, 3, v, r);
      pins = seed[5:3];
      pll_lock = seed[6];
      repeat (8) @(negedge clk);
      check("ref_en", enr, (i < 3) ? pins.oe_ref : seed[2]);
      check("en2", en2, (i < 3) ? pins.oe_two : seed[1]);
      check("en1", en1, (i < 3) ? pins.oe_one : seed[0]);
      host.frame(8'h2F, 3, '0, r);
      check("lock", r[23:0], `SCFG_R_LOCK | ({23'h0, seed[6]} << `SCFG_B_LOCK));
    end
    wrap_up();
  end
endmodule // testbench
